// ===== verilog/uscr_pkg.sv
// Register map, field positions and timing constants of the bus status/control block
package uscr_pkg;
  // Register offsets
  localparam logic [7:0] off_bus_status_control = 8'h1a;
  localparam logic [7:0] off_endpoint_event_mode_select = 8'h1b;
  localparam logic [7:0] off_irq_status = 8'h1c;
  localparam logic [7:0] off_irq_clear = 8'h1d;
  localparam logic [7:0] off_irq_enable = 8'h1e;
  // Bus status/control fields
  localparam int bsc_suspend = 0;
  localparam int bsc_wakeup = 1;
  localparam int bsc_bus_reset = 2;
  localparam int bsc_resume = 3;
  localparam int bsc_data_in = 4;
  localparam int bsc_clock_in = 5;
  localparam int bsc_data_out = 6;
  localparam int bsc_clock_out = 7;
  // Endpoint event / mode select fields
  localparam int ems_ep0 = 0;
  localparam int ems_ep1 = 1;
  localparam int ems_legacy = 4;
  localparam int ems_host_link = 5;
  localparam int ems_usb_flag = 7;
  // Writable bits of the endpoint register; reserved bits read zero
  localparam logic [7:0] ems_write_mask = 8'hb3;
  // Interrupt status fields
  localparam int irq_ep0 = 0;
  localparam int irq_ep1 = 1;
  localparam int irq_suspend = 2;
  localparam int irq_resume = 3;
  localparam int irq_bus_reset = 4;
  localparam int irq_width = 5;
  // Idle time before suspend
  localparam int suspend_idle_us = 3000;
  localparam int clock_mhz = 125;
  localparam int suspend_idle_cycles = suspend_idle_us * clock_mhz;
  localparam int idle_cnt_width = 20;
endpackage : uscr_pkg

// ===== verilog/uscr_regs.sv
// Status and control register pair for the USB / PS/2 mouse serial port
module uscr_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // USB engine events
  input wire logic bus_activity,
  input wire logic bus_reset_seen,
  input wire logic resume_seen,
  input wire logic ep0_access,
  input wire logic ep1_access,
  input wire logic usb_int_enable,
  input wire logic stack_full,
  // USB engine pin drive
  input wire logic engine_minus_out,
  input wire logic engine_plus_out,
  input wire logic engine_oe,
  // Serial bus pins: minus is PS/2 data, plus is PS/2 clock
  input wire logic bus_minus_line_in,
  input wire logic bus_plus_line_in,
  output logic bus_minus_line_out,
  output logic bus_plus_line_out,
  output logic bus_minus_line_oe,
  output logic bus_plus_line_oe,
  // Status toward the rest of the chip
  output logic remote_wakeup_request,
  output logic legacy_mode,
  output logic usb_irq,
  output logic irq
);
  logic suspended;
  logic bus_reset_event_flag;
  logic resume_flag;
  logic serial_data_line_out;
  logic serial_clock_line_out;
  logic control_endpoint_event;
  logic interrupt_endpoint_event;
  logic legacy_bus_select_bit;
  logic host_link_select_bit;
  logic usb_mode_flag;
  logic [uscr_pkg::idle_cnt_width-1:0] idle_cnt;
  logic [uscr_pkg::irq_width-1:0] irq_status;
  logic [uscr_pkg::irq_width-1:0] irq_enable;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Sticky flag: a hardware set beats a firmware write in the same cycle
  function automatic logic sticky(input logic set, input logic wr_en, input logic wbit,
                                  input logic cur);
    sticky = set || (wr_en ? wbit : cur);
  endfunction : sticky

  wire wr_bsc = wr && hit(addr, uscr_pkg::off_bus_status_control);
  wire wr_ems = wr && hit(addr, uscr_pkg::off_endpoint_event_mode_select);
  wire wr_iclr = wr && hit(addr, uscr_pkg::off_irq_clear);
  wire wr_ien = wr && hit(addr, uscr_pkg::off_irq_enable);
  wire [7:0] ems_wdata = wdata & uscr_pkg::ems_write_mask;
  wire ps2_mode = legacy_bus_select_bit && !host_link_select_bit;
  wire usb_mode = host_link_select_bit && !legacy_bus_select_bit;
  wire idle_done = (idle_cnt == uscr_pkg::idle_cnt_width'(uscr_pkg::suspend_idle_cycles));
  wire enter_suspend = usb_mode && !suspended && idle_done && !bus_activity;
  wire leave_suspend = suspended && bus_activity;
  // Access to an endpoint whose flag is still set is held off
  wire ep0_new = ep0_access && !control_endpoint_event;
  wire ep1_new = ep1_access && !interrupt_endpoint_event;
  // Line levels as sampled; outside PS/2 mode the read is forced to 0
  wire data_in_level = ps2_mode ? bus_minus_line_in : 1'b0;
  wire clock_in_level = ps2_mode ? bus_plus_line_in : 1'b0;

  wire [7:0] bsc_read = {2'b00, clock_in_level, data_in_level, resume_flag,
                         bus_reset_event_flag, 1'b0, suspended};
  wire [7:0] ems_read = {usb_mode_flag, 1'b0, host_link_select_bit, legacy_bus_select_bit,
                         2'b00, interrupt_endpoint_event, control_endpoint_event};
  wire [7:0] next_rdata =
      hit(addr, uscr_pkg::off_bus_status_control) ? bsc_read :
      hit(addr, uscr_pkg::off_endpoint_event_mode_select) ? ems_read :
      hit(addr, uscr_pkg::off_irq_status) ? {3'b000, irq_status} :
      hit(addr, uscr_pkg::off_irq_enable) ? {3'b000, irq_enable} : 8'h00;

  wire [uscr_pkg::irq_width-1:0] irq_events = {bus_reset_seen, resume_seen, enter_suspend,
                                                ep1_new, ep0_new};
  // Set wins over a clear in the same cycle
  wire [uscr_pkg::irq_width-1:0] next_irq_status =
      (irq_status & ~(wr_iclr ? wdata[uscr_pkg::irq_width-1:0] : '0)) | irq_events;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // Idle timer restarts on any bus activity
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idle_cnt <= '0;
    end else if (bus_activity || !usb_mode) begin
      idle_cnt <= '0;
    end else if (!idle_done) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      suspended <= 1'b0;
    end else if (enter_suspend) begin
      suspended <= 1'b1;
    end else if (leave_suspend) begin
      suspended <= 1'b0;
    end
  end

  chk_suspend_exit: assert property (@(posedge clock) disable iff (rst)
      leave_suspend |=> !suspended)
    else $error("suspend held through bus activity");
  chk_suspend_irq: assert property (@(posedge clock) disable iff (rst)
      enter_suspend && usb_int_enable && !stack_full |=> usb_irq && suspended)
    else $error("suspend entry gave no interrupt");

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remote_wakeup_request <= 1'b0;
      serial_data_line_out <= 1'b1;
      serial_clock_line_out <= 1'b1;
    end else if (wr_bsc) begin
      remote_wakeup_request <= wdata[uscr_pkg::bsc_wakeup];
      serial_data_line_out <= wdata[uscr_pkg::bsc_data_out];
      serial_clock_line_out <= wdata[uscr_pkg::bsc_clock_out];
    end
  end

  chk_wakeup_set: assert property (@(posedge clock) disable iff (rst)
      wr_bsc && wdata[uscr_pkg::bsc_wakeup] |=> remote_wakeup_request)
    else $error("wake-up request not raised");
  chk_wakeup_clear: assert property (@(posedge clock) disable iff (rst)
      wr_bsc && !wdata[uscr_pkg::bsc_wakeup] |=> !remote_wakeup_request)
    else $error("wake-up request not dropped");
  chk_data_out_write: assert property (@(posedge clock) disable iff (rst)
      wr_bsc && !wdata[uscr_pkg::bsc_data_out] |=> !serial_data_line_out)
    else $error("data line output bit not cleared");
  chk_clock_out_write: assert property (@(posedge clock) disable iff (rst)
      wr_bsc && wdata[uscr_pkg::bsc_clock_out] |=> serial_clock_line_out)
    else $error("clock line output bit not set");

  // Hardware set beats a firmware write in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_reset_event_flag <= 1'b0;
      resume_flag <= 1'b0;
    end else begin
      bus_reset_event_flag <= sticky(bus_reset_seen, wr_bsc, wdata[uscr_pkg::bsc_bus_reset],
                                     bus_reset_event_flag);
      // Resume flag clears when the link leaves suspend, so firmware must note it first
      resume_flag <= resume_seen || (resume_flag && !leave_suspend);
    end
  end

  chk_resume_flag: assert property (@(posedge clock) disable iff (rst)
      resume_seen |=> resume_flag)
    else $error("resume not flagged");
  chk_resume_read_only: assert property (@(posedge clock) disable iff (rst)
      wr_bsc && !resume_seen && !leave_suspend |=> $stable(resume_flag))
    else $error("resume flag changed by a write");
  chk_bus_reset_write: assert property (@(posedge clock) disable iff (rst)
      wr_bsc && !wdata[uscr_pkg::bsc_bus_reset] && !bus_reset_seen |=> !bus_reset_event_flag)
    else $error("bus reset flag not cleared by a write");

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control_endpoint_event <= 1'b0;
      interrupt_endpoint_event <= 1'b0;
    end else begin
      control_endpoint_event <= sticky(ep0_new, wr_ems, wdata[uscr_pkg::ems_ep0],
                                       control_endpoint_event);
      interrupt_endpoint_event <= sticky(ep1_new, wr_ems, wdata[uscr_pkg::ems_ep1],
                                         interrupt_endpoint_event);
    end
  end

  chk_ep1_hold: assert property (@(posedge clock) disable iff (rst)
      interrupt_endpoint_event && !wr_ems |=> interrupt_endpoint_event)
    else $error("endpoint 1 flag dropped without a write");
  chk_ep1_irq_gate: assert property (@(posedge clock) disable iff (rst)
      ep1_new && usb_int_enable && !stack_full |=> usb_irq)
    else $error("endpoint 1 event gave no interrupt");

  // Reserved bits are dropped by the mask, so a stray 1 does no harm
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      legacy_bus_select_bit <= 1'b0;
      host_link_select_bit <= 1'b0;
      usb_mode_flag <= 1'b0;
    end else if (wr_ems) begin
      legacy_bus_select_bit <= ems_wdata[uscr_pkg::ems_legacy];
      host_link_select_bit <= ems_wdata[uscr_pkg::ems_host_link];
      usb_mode_flag <= ems_wdata[uscr_pkg::ems_usb_flag];
    end
  end

  chk_legacy_select: assert property (@(posedge clock) disable iff (rst)
      wr_ems && wdata[uscr_pkg::ems_legacy] |=> legacy_bus_select_bit)
    else $error("PS/2 select bit not taken");
  chk_host_select: assert property (@(posedge clock) disable iff (rst)
      wr_ems && wdata[uscr_pkg::ems_host_link] |=> host_link_select_bit)
    else $error("USB select bit not taken");
  chk_usb_flag_hold: assert property (@(posedge clock) disable iff (rst)
      !wr_ems |=> $stable(usb_mode_flag))
    else $error("USB flag changed without a write");
  chk_ems_reserved: assert property (@(posedge clock) disable iff (rst)
      rd && hit(addr, uscr_pkg::off_endpoint_event_mode_select) |=>
          (rdata & ~uscr_pkg::ems_write_mask) == 8'h00)
    else $error("reserved endpoint bits read non-zero");

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_ien) begin
        irq_enable <= wdata[uscr_pkg::irq_width-1:0];
      end
    end
  end

  chk_irq_ep0_status: assert property (@(posedge clock) disable iff (rst)
      ep0_new |=> irq_status[uscr_pkg::irq_ep0])
    else $error("endpoint 0 status not set");
  chk_irq_ep1_status: assert property (@(posedge clock) disable iff (rst)
      ep1_new |=> irq_status[uscr_pkg::irq_ep1])
    else $error("endpoint 1 status not set");
  chk_irq_suspend_status: assert property (@(posedge clock) disable iff (rst)
      enter_suspend |=> irq_status[uscr_pkg::irq_suspend])
    else $error("suspend status not set");
  chk_irq_resume_status: assert property (@(posedge clock) disable iff (rst)
      resume_seen |=> irq_status[uscr_pkg::irq_resume])
    else $error("resume status not set");
  chk_irq_reset_status: assert property (@(posedge clock) disable iff (rst)
      bus_reset_seen |=> irq_status[uscr_pkg::irq_bus_reset])
    else $error("bus reset status not set");

  // One-cycle USB interrupt toward the core on each new endpoint event, suspend entry or suspend exit, when enabled and the stack is not full
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      usb_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      usb_irq <= usb_int_enable && !stack_full &&
                 (ep0_new || ep1_new || enter_suspend || leave_suspend);
      irq <= |(next_irq_status & irq_enable);
    end
  end

  // Pins: open drain in PS/2 mode, engine drive in USB mode, released otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_minus_line_out <= 1'b0;
      bus_plus_line_out <= 1'b0;
      bus_minus_line_oe <= 1'b0;
      bus_plus_line_oe <= 1'b0;
      legacy_mode <= 1'b0;
    end else begin
      bus_minus_line_out <= usb_mode ? engine_minus_out : 1'b0;
      bus_plus_line_out <= usb_mode ? engine_plus_out : 1'b0;
      bus_minus_line_oe <= usb_mode ? engine_oe : (ps2_mode && !serial_data_line_out);
      bus_plus_line_oe <= usb_mode ? engine_oe : (ps2_mode && !serial_clock_line_out);
      legacy_mode <= ps2_mode;
    end
  end

  chk_engine_drive: assert property (@(posedge clock) disable iff (rst)
      usb_mode |=> bus_plus_line_out == $past(engine_plus_out) &&
          bus_minus_line_out == $past(engine_minus_out) &&
          bus_plus_line_oe == $past(engine_oe))
    else $error("engine does not drive the pins");
  chk_pins_released: assert property (@(posedge clock) disable iff (rst)
      !usb_mode && !ps2_mode |=> !bus_minus_line_oe && !bus_plus_line_oe)
    else $error("pins driven with no mode selected");
  chk_ps2_clock_low: assert property (@(posedge clock) disable iff (rst)
      ps2_mode && !serial_clock_line_out |=> bus_plus_line_oe && !bus_plus_line_out)
    else $error("clock line not pulled low");
  chk_ps2_release: assert property (@(posedge clock) disable iff (rst)
      ps2_mode && serial_data_line_out && serial_clock_line_out |=>
          !bus_minus_line_oe && !bus_plus_line_oe)
    else $error("line held low with its output bit set");
  chk_data_in_read: assert property (@(posedge clock) disable iff (rst)
      rd && hit(addr, uscr_pkg::off_bus_status_control) && ps2_mode |=>
          rdata[uscr_pkg::bsc_data_in] == $past(bus_minus_line_in))
    else $error("data line level read wrong");
  chk_clock_in_read: assert property (@(posedge clock) disable iff (rst)
      rd && hit(addr, uscr_pkg::off_bus_status_control) && ps2_mode |=>
          rdata[uscr_pkg::bsc_clock_in] == $past(bus_plus_line_in))
    else $error("clock line level read wrong");

  chk_ep0_hold: assert property (@(posedge clock) disable iff (rst)
      control_endpoint_event && !wr_ems |=> control_endpoint_event)
    else $error("endpoint 0 flag dropped without a write");
  chk_ep0_set: assert property (@(posedge clock) disable iff (rst)
      ep0_new |=> control_endpoint_event)
    else $error("endpoint 0 access not flagged");
  chk_ep1_set: assert property (@(posedge clock) disable iff (rst)
      ep1_new |=> interrupt_endpoint_event)
    else $error("endpoint 1 access not flagged");
  chk_usb_irq_gate: assert property (@(posedge clock) disable iff (rst)
      ep0_new && usb_int_enable && !stack_full |=> usb_irq)
    else $error("endpoint event gave no interrupt");
  chk_irq_blocked: assert property (@(posedge clock) disable iff (rst)
      (!usb_int_enable || stack_full) |=> !usb_irq)
    else $error("interrupt raised while blocked");
  chk_suspend_idle: assert property (@(posedge clock) disable iff (rst)
      $rose(suspended) |-> $past(idle_done) && $past(usb_mode))
    else $error("suspend without idle time");
  chk_ps2_open_drain: assert property (@(posedge clock) disable iff (rst)
      ps2_mode && !usb_mode && !serial_data_line_out |=> bus_minus_line_oe && !bus_minus_line_out)
    else $error("data line not pulled low");
  chk_read_latency: assert property (@(posedge clock) disable iff (rst)
      rd && hit(addr, uscr_pkg::off_bus_status_control) |=> rdata[0] == $past(suspended))
    else $error("suspend bit read wrong");
  chk_bus_reset_flag: assert property (@(posedge clock) disable iff (rst)
      bus_reset_seen |=> bus_reset_event_flag)
    else $error("bus reset not flagged");
endmodule : uscr_regs

// ===== dv/uscr_host_model.sv
// Far side of the serial pins: host with pull-ups on both lines
module uscr_host_model (
  // Pin drive from the block
  input wire logic minus_out,
  input wire logic minus_oe,
  input wire logic plus_out,
  input wire logic plus_oe,
  // Host pulls a line low on command
  input wire logic pull_data_low,
  input wire logic pull_clock_low,
  // Resolved line levels
  output logic minus_in,
  output logic plus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released lines float to the pull-up, never to the last driven value
  assign minus_in = ((minus_oe && !minus_out) || pull_data_low) ? 1'b0 : 1'b1;
  assign plus_in = ((plus_oe && !plus_out) || pull_clock_low) ? 1'b0 : 1'b1;
endmodule : uscr_host_model

// ===== dv/uscr_regs_tb_top.sv
// Self-checking bench of the status and control register pair
module uscr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, wr = 0, rd = 0, act = 0, ien = 1, sfull = 0, eoe = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic [3:0] evt = 4'h0;
  logic [1:0] host_low = 2'h0;
  logic mo, po, moe, poe, mi, pi, wake, leg, uirq, irq;
  int miscompares = 0, compares = 0, pulses = 0;
  uscr_regs u_uscr_regs (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .bus_activity(act), .bus_reset_seen(evt[2]),
    .resume_seen(evt[3]), .ep0_access(evt[0]), .ep1_access(evt[1]), .usb_int_enable(ien),
    .stack_full(sfull), .engine_minus_out(1'b1), .engine_plus_out(1'b0), .engine_oe(eoe),
    .bus_minus_line_in(mi), .bus_plus_line_in(pi), .bus_minus_line_out(mo),
    .bus_plus_line_out(po), .bus_minus_line_oe(moe), .bus_plus_line_oe(poe),
    .remote_wakeup_request(wake), .legacy_mode(leg), .usb_irq(uirq), .irq(irq));
  uscr_host_model u_uscr_host_model (.minus_out(mo), .minus_oe(moe), .plus_out(po),
    .plus_oe(poe), .pull_data_low(host_low[0]), .pull_clock_low(host_low[1]),
    .minus_in(mi), .plus_in(pi));
  initial begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (uirq === 1'b1) pulses++;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    v = rdata;
  endtask : rd_reg
  task automatic pulse(input int k);
    @(posedge clock);
    evt[k] <= 1'b1;
    @(posedge clock);
    evt[k] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : pulse
  task automatic t_reset;
    rd_reg(8'h1a); chk("bsc reset", v, 8'h00);
    rd_reg(8'h1b); chk("ems reset", v, 8'h00);
    chk("pins released", {leg, moe, poe, wake}, 8'h00);
    wr_reg(8'h1b, 8'h10); rd_reg(8'h1a); chk("outs reset high", v, 8'h30);
    chk("lines released", {6'h0, moe, poe}, 8'h00);
    wr_reg(8'h1b, 8'h00);
  endtask : t_reset
  task automatic t_wakeup;
    wr_reg(8'h1a, 8'hc2); rd_reg(8'h1a);
    chk("wakeup level", {7'h0, wake}, 8'h01);
    chk("wakeup reads 0", v, 8'h00);
    wr_reg(8'h1a, 8'hc0); rd_reg(8'h1a);
    chk("wakeup off", {7'h0, wake}, 8'h00);
  endtask : t_wakeup
  task automatic t_events;
    pulse(2); pulse(3); rd_reg(8'h1a);
    chk("reset and resume flags", v, 8'h0c);
    wr_reg(8'h1a, 8'hc0); rd_reg(8'h1a);
    chk("reset flag cleared", v, 8'h08);
    wr_reg(8'h1e, 8'h10); rd_reg(8'h1e); chk("irq enable", v, 8'h10);
    chk("irq raised", {7'h0, irq}, 8'h01);
    wr_reg(8'h1e, 8'h00); rd_reg(8'h1c); chk("irq masked", {7'h0, irq}, 8'h00);
    chk("irq status", v, 8'h18);
    wr_reg(8'h1e, 8'h10); wr_reg(8'h1d, 8'h10); rd_reg(8'h1c);
    chk("irq cleared", {7'h0, irq}, 8'h00);
  endtask : t_events
  task automatic t_endpoints;
    pulses = 0; pulse(0); chk("ep0 irq", 8'(pulses), 8'h01);
    pulse(0); chk("ep0 held", 8'(pulses), 8'h01);
    sfull <= 1'b1; pulse(1); chk("stack full", 8'(pulses), 8'h01);
    rd_reg(8'h1b); chk("ep flags", v, 8'h03);
    sfull <= 1'b0; ien <= 1'b0; wr_reg(8'h1b, 8'h02); pulse(0);
    chk("irq disabled", 8'(pulses), 8'h01);
    ien <= 1'b1; wr_reg(8'h1b, 8'h00); pulse(1);
    chk("ep1 irq", 8'(pulses), 8'h02);
    rd_reg(8'h1b); chk("ep1 only", v, 8'h02);
  endtask : t_endpoints
  task automatic t_modes;
    wr_reg(8'h1b, 8'h90); rd_reg(8'h1b); chk("legacy select", v, 8'h90);
    chk("legacy mode", {7'h0, leg}, 8'h01);
    rd_reg(8'h1a); chk("lines idle high", v, 8'h38);
    wr_reg(8'h1a, 8'h40); rd_reg(8'h1a); chk("clock pulled", v, 8'h18);
    chk("clock drive", {6'h0, poe, po}, 8'h02);
    wr_reg(8'h1a, 8'hc0); host_low <= 2'h1; rd_reg(8'h1a);
    chk("host data low", v, 8'h28);
    host_low <= 2'h0; eoe <= 1'b1; wr_reg(8'h1b, 8'ha0); rd_reg(8'h1a);
    chk("usb lines", {leg, moe, mo, poe, po, v[5:4], 1'b0}, 8'h70);
    rd_reg(8'h1b); chk("usb flag held", v, 8'ha0);
    wr_reg(8'h55, 8'hff); rd_reg(8'h55); chk("unmapped", v, 8'h00);
  endtask : t_modes
  task automatic finish_test;
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_wakeup();
    t_events();
    t_endpoints();
    t_modes();
    finish_test();
  end
endmodule : uscr_regs_tb_top
